// *** ptp_regs.svh ***
// offsets, field positions, reset values and duty encodings for the
// power-regulation and two-phase profile register bank
// assumes inclusion from the package and the design files by bare name
`ifndef PTP_REGS_SVH
`define PTP_REGS_SVH

`define PTP_ADDR_W          8
`define PTP_DATA_W          32
`define PTP_PWR_CFG_ADDR    8'h90
`define PTP_TWO_PH_ADDR     8'h96
`define PTP_PWR_CFG_RESET   32'h0000_0000
`define PTP_TWO_PH_RESET    32'h0000_0000

`define PTP_PARITY_BIT      31
`define PTP_MAX_SPEED_HI    30
`define PTP_MAX_SPEED_LO    15
`define PTP_DT_COMP_BIT     14
`define PTP_MAX_POWER_HI    13
`define PTP_MAX_POWER_LO    4
`define PTP_HYST_HI         3
`define PTP_HYST_LO         2
`define PTP_MODE_HI         1
`define PTP_MODE_LO         0

`define PTP_STEP_COUNT      8
`define PTP_STEP_W          3
`define PTP_STEP0_HI        30
`define PTP_RSVD_HI         6
`define PTP_RSVD_LO         0

// duty levels in hundredths of a percent
`define PTP_DUTY_W          14
`define PTP_DUTY_0          14'd0
`define PTP_DUTY_1          14'd5000
`define PTP_DUTY_2          14'd7500
`define PTP_DUTY_3          14'd8375
`define PTP_DUTY_4          14'd8750
`define PTP_DUTY_5          14'd9375
`define PTP_DUTY_6          14'd9750
`define PTP_DUTY_7          14'd9900

// hysteresis in tenths of a percent
`define PTP_HYST_PCT_W      7
`define PTP_HYST_0          7'd50
`define PTP_HYST_1          7'd75
`define PTP_HYST_2          7'd100
`define PTP_HYST_3          7'd125

`endif

// *** ptp_pkg.sv ***
// types shared by the register bank and its duty decoder
// assumes ptp_regs.svh on the include path
`default_nettype none
`include "ptp_regs.svh"

package ptp_pkg;
    typedef enum logic [1:0]
    {
        PTP_MODE_OFF       = 2'h0,
        PTP_MODE_CLOSED    = 2'h1,
        PTP_MODE_LIMIT     = 2'h2,
        PTP_MODE_RESERVED  = 2'h3
    } ptp_mode_t;

    typedef logic [`PTP_STEP_W-1:0]   ptp_step_t;
    typedef logic [`PTP_DUTY_W-1:0]   ptp_duty_t;
    typedef logic [`PTP_DATA_W-1:0]   ptp_word_t;
    typedef logic [`PTP_ADDR_W-1:0]   ptp_addr_t;
endpackage
`default_nettype wire

// *** ptp_duty_decode.sv ***
// maps one 3-bit step-duty code to its duty level
// assumes a registered code at its input; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "ptp_regs.svh"

module ptp_duty_decode
(
    input  wire ptp_pkg::ptp_step_t code,
    output var  ptp_pkg::ptp_duty_t duty
);
    import ptp_pkg::*;

    always_comb
    begin
        case (code)
            3'h0:    duty = `PTP_DUTY_0;
            3'h1:    duty = `PTP_DUTY_1;
            3'h2:    duty = `PTP_DUTY_2;
            3'h3:    duty = `PTP_DUTY_3;
            3'h4:    duty = `PTP_DUTY_4;
            3'h5:    duty = `PTP_DUTY_5;
            3'h6:    duty = `PTP_DUTY_6;
            3'h7:    duty = `PTP_DUTY_7;
            default: duty = `PTP_DUTY_0;
        endcase
    end
endmodule
`default_nettype wire

// *** ptp_regs_bank.sv ***
// power-regulation and two-phase duty profile register bank
// assumes the serial register interface delivers one-cycle word strobes
// with address, all synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "ptp_regs.svh"

module ptp_regs_bank
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    input  wire ptp_pkg::ptp_addr_t  addr,
    input  wire ptp_pkg::ptp_word_t  wr_data,
    output var  ptp_pkg::ptp_word_t  rd_data,
    output var  logic                rd_valid,
    output var  logic                rd_hit,
    output var  logic [15:0]         max_speed_code,
    output var  logic                dead_time_correction_on,
    output var  logic [9:0]          max_power_code,
    output var  logic [1:0]          power_regulation_hysteresis,
    output var  logic [6:0]          hysteresis_tenth_pct,
    output var  ptp_pkg::ptp_mode_t  regulation_mode,
    output var  logic [6:0]          two_phase_reserved,
    output var  ptp_pkg::ptp_step_t  two_phase_duty_step_0,
    output var  ptp_pkg::ptp_step_t  two_phase_duty_step_1,
    output var  ptp_pkg::ptp_step_t  two_phase_duty_step_2,
    output var  ptp_pkg::ptp_step_t  two_phase_duty_step_3,
    output var  ptp_pkg::ptp_step_t  two_phase_duty_step_4,
    output var  ptp_pkg::ptp_step_t  two_phase_duty_step_5,
    output var  ptp_pkg::ptp_step_t  two_phase_duty_step_6,
    output var  ptp_pkg::ptp_step_t  two_phase_duty_step_7,
    output var  ptp_pkg::ptp_duty_t  step_duty [`PTP_STEP_COUNT]
);
    import ptp_pkg::*;

    ptp_word_t  power_regulation_config;
    ptp_word_t  two_phase_duty_profile;
    ptp_word_t  next_power_regulation_config;
    ptp_word_t  next_two_phase_duty_profile;
    ptp_word_t  next_rd_data;
    logic       next_rd_valid;
    logic       next_rd_hit;
    ptp_duty_t  duty_comb [`PTP_STEP_COUNT];
    ptp_duty_t  next_step_duty [`PTP_STEP_COUNT];
    logic [6:0] next_hyst_pct;
    logic       pwr_sel;
    logic       two_ph_sel;

    function automatic ptp_step_t step_field(input ptp_word_t w,
                                             input int        idx);
        int lo;
        lo = `PTP_STEP0_HI - `PTP_STEP_W * idx - (`PTP_STEP_W - 1);
        return ptp_step_t'(w >> lo);
    endfunction

    function automatic logic is_pwr_word(input ptp_addr_t a);
        return a == `PTP_PWR_CFG_ADDR;
    endfunction

    function automatic logic is_two_ph_word(input ptp_addr_t a);
        return a == `PTP_TWO_PH_ADDR;
    endfunction

    // hysteresis code to tenths of a percent
    function automatic logic [6:0] hyst_pct(input logic [1:0] code);
        case (code)
            2'h0:    return `PTP_HYST_0;
            2'h1:    return `PTP_HYST_1;
            2'h2:    return `PTP_HYST_2;
            2'h3:    return `PTP_HYST_3;
            default: return `PTP_HYST_0;
        endcase
    endfunction

    // both selects come from one decode, so reads and writes agree on
    // the map; an address matching neither word drops the write and reads back zero, hit low
    always_comb
    begin
        pwr_sel    = is_pwr_word(addr);
        two_ph_sel = is_two_ph_word(addr);
    end

    // stored words: the read path samples the flops, so a write in the
    // same cycle as a read returns the old value
    always_comb
    begin
        next_power_regulation_config = power_regulation_config;
        next_two_phase_duty_profile  = two_phase_duty_profile;
        if (wr_en && pwr_sel)
            next_power_regulation_config = wr_data;
        if (wr_en && two_ph_sel)
            next_two_phase_duty_profile = wr_data;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            power_regulation_config <= `PTP_PWR_CFG_RESET;
            two_phase_duty_profile  <= `PTP_TWO_PH_RESET;
        end
        else
        begin
            power_regulation_config <= next_power_regulation_config;
            two_phase_duty_profile  <= next_two_phase_duty_profile;
        end
    end

    // read return: an unmapped read is still answered, hit low and data
    // zero, so the serial front end never waits on a missing word
    always_comb
    begin
        next_rd_valid = rd_en;
        next_rd_hit   = 1'b0;
        next_rd_data  = 32'h0000_0000;
        if (rd_en)
        begin
            case ({pwr_sel, two_ph_sel})
                2'h2:
                begin
                    next_rd_data = power_regulation_config;
                    next_rd_hit  = 1'b1;
                end
                2'h1:
                begin
                    next_rd_data = two_phase_duty_profile;
                    next_rd_hit  = 1'b1;
                end
                default:
                begin
                    next_rd_data = 32'h0000_0000;
                    next_rd_hit  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data  <= 32'h0000_0000;
            rd_valid <= 1'b0;
            rd_hit   <= 1'b0;
        end
        else
        begin
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
            rd_hit   <= next_rd_hit;
        end
    end

    // levels are registered so each output leaves a flop; the price is
    // one cycle of lag behind the stored word
    always_comb
    begin
        for (int i = 0; i < `PTP_STEP_COUNT; i++)
            next_step_duty[i] = duty_comb[i];
        next_hyst_pct = hyst_pct(power_regulation_config[`PTP_HYST_HI:
                                                         `PTP_HYST_LO]);
    end

    // one decoder per step, each fed only its own 3-bit slice
    for (genvar g = 0; g < `PTP_STEP_COUNT; g++)
    begin : g_dec
        ptp_duty_decode u_dec
        (
            .code (step_field(two_phase_duty_profile, g)),
            .duty (duty_comb[g])
        );
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hysteresis_tenth_pct <= `PTP_HYST_0;
            for (int i = 0; i < `PTP_STEP_COUNT; i++)
                step_duty[i] <= `PTP_DUTY_0;
        end
        else
        begin
            hysteresis_tenth_pct <= next_hyst_pct;
            for (int i = 0; i < `PTP_STEP_COUNT; i++)
                step_duty[i] <= next_step_duty[i];
        end
    end

    // parity bit 31 is stored and read back only; nothing checks it here
    // field outputs are straight slices of the stored words
    always_comb
    begin
        max_speed_code = power_regulation_config[`PTP_MAX_SPEED_HI:
                                                 `PTP_MAX_SPEED_LO];
        dead_time_correction_on =
            power_regulation_config[`PTP_DT_COMP_BIT];
        max_power_code = power_regulation_config[`PTP_MAX_POWER_HI:
                                                 `PTP_MAX_POWER_LO];
        power_regulation_hysteresis =
            power_regulation_config[`PTP_HYST_HI:`PTP_HYST_LO];
        // reserved code 3 is passed on untouched; the consumer treats it
        regulation_mode = ptp_mode_t'(
            power_regulation_config[`PTP_MODE_HI:`PTP_MODE_LO]);
        two_phase_reserved =
            two_phase_duty_profile[`PTP_RSVD_HI:`PTP_RSVD_LO];
        two_phase_duty_step_0 = step_field(two_phase_duty_profile, 0);
        two_phase_duty_step_1 = step_field(two_phase_duty_profile, 1);
        two_phase_duty_step_2 = step_field(two_phase_duty_profile, 2);
        two_phase_duty_step_3 = step_field(two_phase_duty_profile, 3);
        two_phase_duty_step_4 = step_field(two_phase_duty_profile, 4);
        two_phase_duty_step_5 = step_field(two_phase_duty_profile, 5);
        two_phase_duty_step_6 = step_field(two_phase_duty_profile, 6);
        two_phase_duty_step_7 = step_field(two_phase_duty_profile, 7);
    end
endmodule
`default_nettype wire

// *** ptp_regs_monitor.sv ***
// assertion checker for the power and profile register bank
// assumes it is bound to ptp_regs_bank and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "ptp_regs.svh"

module ptp_regs_monitor
(
    input wire logic               clk,
    input wire logic               rst_b,
    input wire logic               wr_en,
    input wire logic               rd_en,
    input wire ptp_pkg::ptp_addr_t addr,
    input wire ptp_pkg::ptp_word_t wr_data,
    input wire ptp_pkg::ptp_word_t rd_data,
    input wire logic               rd_valid,
    input wire logic               rd_hit,
    input wire logic [15:0]        max_speed_code,
    input wire logic               dead_time_correction_on,
    input wire logic [9:0]         max_power_code,
    input wire logic [1:0]         power_regulation_hysteresis,
    input wire logic [6:0]         hysteresis_tenth_pct,
    input wire ptp_pkg::ptp_mode_t regulation_mode,
    input wire logic [6:0]         two_phase_reserved,
    input wire ptp_pkg::ptp_step_t two_phase_duty_step_0,
    input wire ptp_pkg::ptp_step_t two_phase_duty_step_7,
    input wire ptp_pkg::ptp_duty_t step_duty [`PTP_STEP_COUNT]
);
    import ptp_pkg::*;
    localparam ptp_duty_t duty_tab [8] = '{14'h0, 14'h1388, 14'h1d4c,
        14'h20b7, 14'h222e, 14'h249f, 14'h2616, 14'h26ac};
    localparam logic [6:0] hyst_tab [4] = '{7'h32, 7'h4b, 7'h64, 7'h7d};
    // shadows keep what was written; unmapped writes are dropped
    ptp_word_t sh90, sh96, rd_exp, next_sh90, next_sh96, next_rd_exp;

    always_comb
    begin
        next_sh90 = (wr_en && addr == 8'h90) ? wr_data : sh90;
        next_sh96 = (wr_en && addr == 8'h96) ? wr_data : sh96;
        next_rd_exp = addr == 8'h90 ? sh90 : addr == 8'h96 ? sh96 : '0;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            {sh90, sh96, rd_exp} <= '0;
        else
            {sh90, sh96, rd_exp} <= {next_sh90, next_sh96, next_rd_exp};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    rd_answer_a: assert property (rd_en |=> rd_valid)
        else $error("read strobe not answered next cycle");
    rd_hit_a: assert property (rd_en |=> rd_hit ==
        ($past(addr) == 8'h90 || $past(addr) == 8'h96))
        else $error("read hit flag wrong");
    read_back_a: assert property (rd_en |=> rd_data == rd_exp)
        else $error("read data differs from last write");
    speed_field_a: assert property (wr_en && addr == 8'h90 |=>
        max_speed_code == sh90[30:15]) else $error("speed field wrong");
    dead_time_a: assert property (dead_time_correction_on == sh90[14])
        else $error("dead time enable wrong");
    power_fields_a: assert property ({max_power_code,
        power_regulation_hysteresis, regulation_mode} == sh90[13:0])
        else $error("power, hysteresis or mode field wrong");
    step_fields_a: assert property (wr_en && addr == 8'h96 |=>
        {two_phase_duty_step_0, two_phase_duty_step_7,
        two_phase_reserved} == {sh96[30:28], sh96[9:0]})
        else $error("profile step fields wrong");
    duty_map_a: assert property (
        step_duty[7] == duty_tab[$past(two_phase_duty_step_7)])
        else $error("step duty decode wrong");

    hyst_decode_a: assert property (
        hysteresis_tenth_pct == hyst_tab[$past(power_regulation_hysteresis)])
        else $error("hysteresis decode wrong");

    cover property (wr_en && addr == 8'h90 && wr_data[1:0] == 2'h3);
    cover property (rd_en && wr_en && addr == 8'h90);
    cover property (rd_en && addr == 8'h91);
endmodule

bind ptp_regs_bank ptp_regs_monitor ptp_regs_monitor_i
(
    .clk, .rst_b, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid,
    .rd_hit, .max_speed_code, .dead_time_correction_on, .max_power_code,
    .power_regulation_hysteresis, .hysteresis_tenth_pct, .regulation_mode,
    .two_phase_reserved, .two_phase_duty_step_0, .two_phase_duty_step_7,
    .step_duty
);
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the power and profile register bank
// assumes the bank and its bound monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ptp_regs.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_count++; $display("BAD %s exp %h got %h", n, e, g); end end

module tb_top;
    import ptp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    ptp_addr_t   addr = 8'h00;
    ptp_word_t   wr_data = 32'h0;
    ptp_word_t   rd_data, w, w90;
    logic        rd_valid, rd_hit, dtc;
    logic [15:0] spd;
    logic [9:0]  pwr;
    logic [1:0]  hys;
    logic [6:0]  hpct, rsv;
    ptp_mode_t   mode;
    ptp_step_t   s [8];
    ptp_duty_t   sd [8];
    logic [32:0] q [$];
    logic [32:0] e;
    int          err_count = 0;
    int          n_checks = 0;
    localparam ptp_duty_t duty_tab [8] = '{14'h0, 14'h1388, 14'h1d4c,
        14'h20b7, 14'h222e, 14'h249f, 14'h2616, 14'h26ac};
    localparam logic [6:0] hyst_tab [4] = '{7'h32, 7'h4b, 7'h64, 7'h7d};

    always #50 clk = ~clk;

    ptp_regs_bank ptp_regs_bank_i
    (
        .clk, .rst_b, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
        .rd_valid, .rd_hit, .max_speed_code (spd), .max_power_code (pwr),
        .dead_time_correction_on (dtc), .regulation_mode (mode),
        .power_regulation_hysteresis (hys), .hysteresis_tenth_pct (hpct),
        .two_phase_reserved (rsv), .two_phase_duty_step_0 (s[0]),
        .two_phase_duty_step_1 (s[1]), .two_phase_duty_step_2 (s[2]),
        .two_phase_duty_step_3 (s[3]), .two_phase_duty_step_4 (s[4]),
        .two_phase_duty_step_5 (s[5]), .two_phase_duty_step_6 (s[6]),
        .two_phase_duty_step_7 (s[7]), .step_duty (sd)
    );

    // every signal is set once per falling edge, so strobes never glitch
    task automatic op(input logic w_on, r_on, input ptp_addr_t a,
                      input ptp_word_t d);
        @(negedge clk);
        wr_en = w_on;
        rd_en = r_on;
        addr = a;
        wr_data = d;
    endtask

    task automatic rd(input ptp_addr_t a, input logic [32:0] x);
        op(1'b0, 1'b1, a, $urandom);
        q.push_back(x);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(negedge clk)
        if (rd_valid === 1'b1)
        begin
            e = q.pop_front();
            `CHK("read", e, {rd_hit, rd_data})
        end

    initial
    begin
        void'($urandom(32'h5982e442));
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        rd(8'h90, 33'h1_0000_0000);
        rd(8'h96, 33'h1_0000_0000);
        op(1'b0, 1'b0, 8'h00, 32'h0);
        `CHK("hyst pct", 7'h32, hpct)
        `CHK("fields", 38'h0, {spd, dtc, pwr, hys, mode, rsv})
        $display("test reset done");
        w90 = 32'h0;
        // low nibble walks every hysteresis and mode code, reserved too
        for (int i = 0; i < 16; i++)
        begin
            w = $urandom;
            w[3:0] = i[3:0];
            op(1'b1, i == 5, 8'h90, w);
            if (i == 5)
                q.push_back({1'b1, w90});
            op(1'b0, 1'b0, 8'h90, w);
            `CHK("pwr", w[30:0], {spd, dtc, pwr, hys, mode})
            rd(8'h90, {1'b1, w});
            `CHK("hyst pct", hyst_tab[w[3:2]], hpct)
            w90 = w;
        end
        $display("test power word done");
        for (int i = 0; i < 8; i++)
        begin
            w = $urandom;
            w[30:28] = i[2:0];
            op(1'b1, 1'b0, 8'h96, w);
            op(1'b0, 1'b0, 8'h96, w);
            for (int k = 0; k < 8; k++)
                `CHK("step", w[30-3*k -: 3], s[k])
            `CHK("reserved", w[6:0], rsv)
            rd(8'h96, {1'b1, w});
            for (int k = 0; k < 8; k++)
                `CHK("duty", duty_tab[w[30-3*k -: 3]], sd[k])
        end
        $display("test profile done");
        op(1'b1, 1'b0, 8'h91, 32'hffff_ffff);
        rd(8'h91, 33'h0);
        rd(8'h90, {1'b1, w90});
        op(1'b0, 1'b0, 8'h00, 32'h0);
        @(negedge clk);
        rst_b = 1'b0;
        @(negedge clk);
        rst_b = 1'b1;
        rd(8'h96, 33'h1_0000_0000);
        rd(8'h90, 33'h1_0000_0000);
        op(1'b0, 1'b0, 8'h00, 32'h0);
        for (int t = 0; t < 5 && q.size() > 0; t++)
            @(negedge clk);
        if (q.size() > 0)
        begin
            err_count++;
            $display("BAD pending reads exp 0 got %0d", q.size());
        end
        $display("test unmapped and reset done");
        conclude();
    end
endmodule
`default_nettype wire
